//--- pkg/fob_regs.svh
// Purpose: Offsets, field positions, codes and timing counts of the OTP control block.
// Assumes: Word addressing on the flash address pins; 16-bit data.
// Notes: Definitions only.
`ifndef FOB_REGS_SVH
`define FOB_REGS_SVH

`define FOB_ADDR_W 21
`define FOB_DATA_W 16
`define FOB_OTP_WORDS 8
`define FOB_FACTORY_WORDS 4
`define FOB_LOCK_OFFSET 21'h000080
`define FOB_OTP_BASE 21'h000081
`define FOB_LOCK_DATA 16'hfffd
`define FOB_LOCK_FACTORY_BIT 0
`define FOB_LOCK_CUSTOMER_BIT 1
`define FOB_LOCK_IDX 4'h8
`define FOB_ERASED 16'hffff

`define FOB_CMD_READ_ARRAY 8'hff
`define FOB_CMD_READ_ID 8'h90
`define FOB_CMD_OTP_PROGRAM 8'hc0
`define FOB_CMD_READ_STATUS 8'h70
`define FOB_CMD_CLEAR_STATUS 8'h50
`define FOB_CMD_SUSPEND 8'hb0

`define FOB_SR_READY_BIT 7
`define FOB_SR_FAIL_BIT 4
`define FOB_SR_PROTECT_BIT 1

`define FOB_MAIN_BLOCK_SHIFT 15
`define FOB_PARAM_BLOCK_SHIFT 12
`define FOB_PARAM_REGION 6'h3f
`define FOB_FIRST_PARAM_BLOCK 7'h3f

`define FOB_CLK_PERIOD_NS 10
`define FOB_OTP_PROG_NS 2000
`define FOB_OTP_PROG_CYCLES (`FOB_OTP_PROG_NS / `FOB_CLK_PERIOD_NS)

`endif

//--- pkg/fob_pkg.sv
// Purpose: Types shared by the OTP control block.
// Assumes: Constants come from fob_regs.svh.
// Notes: The controller state is a single packed struct.
`default_nettype none
package fob_pkg;
  typedef enum logic [2:0] {
    MODE_ARRAY,
    MODE_IDENT,
    MODE_STATUS,
    MODE_OTP_SETUP,
    MODE_OTP_BUSY
  } fob_mode_type;

  typedef enum logic [1:0] {
    VERDICT_OK,
    VERDICT_FAIL,
    VERDICT_LOCKED
  } fob_verdict_type;

  typedef struct packed {
    fob_mode_type mode;
    fob_verdict_type verdict;
    logic [7:0] busy_cnt;
    logic fail;
    logic protect;
    logic strobe_prev;
    logic [3:0] op_idx;
    logic [15:0] op_data;
    logic [15:0] dq;
    logic dq_oe;
    logic [6:0] blk;
    logic param_blk;
    logic wr_prot;
    logic busy;
  } fob_state_type;
endpackage
`default_nettype wire

//--- pkg/fob_mem_if.sv
// Purpose: Link between the command logic and the OTP storage.
// Assumes: Single clock.
// Notes: Write data is ANDed into the stored word by the storage.
`default_nettype none
interface fob_mem_if;
  logic we;
  logic [3:0] widx;
  logic [15:0] wdata;
  logic [3:0] ridx;
  logic [15:0] rdata;
  modport ctrl (output we, output widx, output wdata, output ridx, input rdata);
  modport mem (input we, input widx, input wdata, input ridx, output rdata);
endinterface
`default_nettype wire

//--- design/fob_otp_mem.sv
// Purpose: Non-volatile OTP words and customer lock bit.
// Assumes: Index 0-7 are data words, index 8 is the lock word.
// Notes: Contents are not reset, so a reset leaves locks and data unchanged.
`include "fob_regs.svh"
`default_nettype none
module fob_otp_mem #(
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89ab_cdef
) (
  input wire logic core_clk_i,
  fob_mem_if.mem port
);
  // The factory number value is arbitrary.
  logic [15:0] cust_reg [0:3];
  logic cust_unlocked_reg;
  logic [15:0] rdata_reg;

  initial begin
    for (int i = 0; i < 4; i++) begin
      cust_reg[i] = `FOB_ERASED;
    end
    cust_unlocked_reg = 1'b1;
  end

  // Programming only clears bits, so no write can erase.
  // A plain always, since the initial block also writes these cells to model erased cells.
  always @(posedge core_clk_i) begin
    if (port.we && port.widx == `FOB_LOCK_IDX) begin
      cust_unlocked_reg <= cust_unlocked_reg & port.wdata[`FOB_LOCK_CUSTOMER_BIT];
    end else if (port.we && port.widx[3:2] == 2'b01) begin
      cust_reg[port.widx[1:0]] <= cust_reg[port.widx[1:0]] & port.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (port.ridx == `FOB_LOCK_IDX) begin
      rdata_reg <= {14'h3fff, cust_unlocked_reg, 1'b0};
    end else if (port.ridx[3:2] == 2'b00) begin
      rdata_reg <= FACTORY_ID[{port.ridx[1:0], 4'h0} +: 16];
    end else if (port.ridx[3:2] == 2'b01) begin
      rdata_reg <= cust_reg[port.ridx[1:0]];
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign port.rdata = rdata_reg;

  a_lock_sticky: assert property (
    @(posedge core_clk_i) !cust_unlocked_reg |=> !cust_unlocked_reg)
    else $error("Customer lock returned to unlocked");
endmodule
`default_nettype wire

//--- design/fob_ctrl.sv
// Purpose: Command interface and OTP block control of a NOR flash array.
// Assumes: All pins are synchronous to core_clk_i; the main array lives outside.
// Notes: Identifier reads return data two clocks after the request, through the storage register; array and status reads one clock.
`include "fob_regs.svh"
`default_nettype none
module fob_ctrl (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic flash_rst_n_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic wp_n_i,
  input wire logic program_supply_monitor_i,
  input wire logic [20:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] array_rdata_i,
  input wire logic block_lock_i,
  input wire logic block_lockdown_i,
  output logic [15:0] dq_o,
  output logic dq_oe_o,
  output logic [6:0] block_num_o,
  output logic param_block_o,
  output logic block_write_protect_o,
  output logic otp_busy_o
);
  fob_pkg::fob_state_type state_reg;
  fob_pkg::fob_state_type state_next;
  fob_mem_if mem_bus ();

  fob_otp_mem fob_otp_mem_i (
    .core_clk_i(core_clk_i),
    .port(mem_bus.mem)
  );

  logic strobe;
  logic capture;
  logic reading;
  logic [7:0] cmd;
  logic [15:0] status;
  logic [3:0] id_idx;

  // Maps a word address to its block in the top-parameter map.
  function automatic logic [6:0] block_of(input logic [20:0] a);
    if (a[20:15] == `FOB_PARAM_REGION) begin
      return `FOB_FIRST_PARAM_BLOCK + {4'h0, a[14:12]};
    end
    return {1'b0, a[20:15]};
  endfunction

  // Maps an identifier-space address to a storage index; 4'hf means none.
  function automatic logic [3:0] otp_index(input logic [20:0] a);
    logic [20:0] d;
    d = a - `FOB_OTP_BASE;
    if (a == `FOB_LOCK_OFFSET) begin
      return `FOB_LOCK_IDX;
    end
    if (a >= `FOB_OTP_BASE && d < 21'(`FOB_OTP_WORDS)) begin
      return d[3:0];
    end
    return 4'hf;
  endfunction

  assign strobe = ~ce_n_i & ~we_n_i;
  assign capture = state_reg.strobe_prev & ~strobe & flash_rst_n_i;
  assign reading = ~ce_n_i & ~oe_n_i & we_n_i;
  assign cmd = dq_i[7:0];
  assign id_idx = otp_index(addr_i);
  assign status = {8'h00, ~state_reg.busy, 2'b00, state_reg.fail, 2'b00, state_reg.protect, 1'b0};

  always_comb begin
    state_next = state_reg;
    state_next.strobe_prev = strobe;
    mem_bus.we = 1'b0;
    mem_bus.widx = state_reg.op_idx;
    mem_bus.wdata = state_reg.op_data;
    mem_bus.ridx = id_idx;
    unique case (state_reg.mode)
      fob_pkg::MODE_ARRAY, fob_pkg::MODE_IDENT, fob_pkg::MODE_STATUS: begin
        if (capture) begin
          unique case (cmd)
            `FOB_CMD_READ_ARRAY: state_next.mode = fob_pkg::MODE_ARRAY;
            `FOB_CMD_READ_ID: state_next.mode = fob_pkg::MODE_IDENT;
            `FOB_CMD_READ_STATUS: state_next.mode = fob_pkg::MODE_STATUS;
            `FOB_CMD_OTP_PROGRAM: state_next.mode = fob_pkg::MODE_OTP_SETUP;
            `FOB_CMD_CLEAR_STATUS: begin
              state_next.fail = 1'b0;
              state_next.protect = 1'b0;
            end
            default: state_next.mode = state_reg.mode;
          endcase
        end
      end
      fob_pkg::MODE_OTP_SETUP: begin
        if (capture) begin
          // Second cycle: the target and data are judged now, written at the end.
          state_next.mode = fob_pkg::MODE_OTP_BUSY;
          state_next.busy = 1'b1;
          state_next.busy_cnt = 8'(`FOB_OTP_PROG_CYCLES - 1);
          state_next.op_idx = id_idx;
          state_next.op_data = dq_i;
          if (id_idx == 4'hf || !program_supply_monitor_i) begin
            state_next.verdict = fob_pkg::VERDICT_FAIL;
          end else if (id_idx == `FOB_LOCK_IDX) begin
            state_next.verdict = fob_pkg::VERDICT_OK;
          end else if (id_idx[3:2] == 2'b00 || !mem_bus.rdata[`FOB_LOCK_CUSTOMER_BIT]) begin
            state_next.verdict = fob_pkg::VERDICT_LOCKED;
          end else begin
            state_next.verdict = fob_pkg::VERDICT_OK;
          end
        end
      end
      fob_pkg::MODE_OTP_BUSY: begin
        // Commands, suspend included, are not decoded until the write ends.
        if (state_reg.busy_cnt != 8'h00) begin
          state_next.busy_cnt = state_reg.busy_cnt - 8'h01;
        end else begin
          state_next.mode = fob_pkg::MODE_STATUS;
          state_next.busy = 1'b0;
          mem_bus.we = state_reg.verdict == fob_pkg::VERDICT_OK;
          if (state_reg.verdict != fob_pkg::VERDICT_OK) begin
            state_next.fail = 1'b1;
          end
          if (state_reg.verdict == fob_pkg::VERDICT_LOCKED) begin
            state_next.protect = 1'b1;
          end
        end
      end
    endcase
    // The lock word must be read during the second cycle to judge the target.
    if (state_reg.mode == fob_pkg::MODE_OTP_SETUP) begin
      mem_bus.ridx = `FOB_LOCK_IDX;
    end
    if (state_reg.mode == fob_pkg::MODE_OTP_BUSY || state_reg.mode == fob_pkg::MODE_STATUS ||
        state_reg.mode == fob_pkg::MODE_OTP_SETUP) begin
      state_next.dq = status;
    end else if (state_reg.mode == fob_pkg::MODE_IDENT) begin
      state_next.dq = mem_bus.rdata;
    end else begin
      state_next.dq = array_rdata_i;
    end
    state_next.dq_oe = reading;
    state_next.blk = block_of(addr_i);
    state_next.param_blk = addr_i[20:15] == `FOB_PARAM_REGION;
    state_next.wr_prot = ~program_supply_monitor_i | ~flash_rst_n_i | block_lock_i |
                         (block_lockdown_i & ~wp_n_i);
    if (!flash_rst_n_i) begin
      state_next.mode = fob_pkg::MODE_ARRAY;
      mem_bus.we = 1'b0;
      state_next.busy = 1'b0;
      state_next.busy_cnt = 8'h00;
    end
  end

  // Only the command logic is reset; OTP contents and locks stay put.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dq_o = state_reg.dq;
  assign dq_oe_o = state_reg.dq_oe;
  assign block_num_o = state_reg.blk;
  assign param_block_o = state_reg.param_blk;
  assign block_write_protect_o = state_reg.wr_prot;
  assign otp_busy_o = state_reg.busy;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  logic [8:0] busy_len;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_len <= 9'h000;
    end else if (otp_busy_o) begin
      busy_len <= busy_len + 9'h001;
    end else begin
      busy_len <= 9'h000;
    end
  end

  sequence s_second_cycle;
    state_reg.mode == fob_pkg::MODE_OTP_SETUP && capture;
  endsequence

  sequence s_write_end;
    state_reg.mode == fob_pkg::MODE_OTP_BUSY && state_reg.busy_cnt == 8'h00;
  endsequence

  // A command cycle taken while no program is pending or running.
  sequence s_idle_command;
    capture && (state_reg.mode == fob_pkg::MODE_ARRAY || state_reg.mode == fob_pkg::MODE_IDENT
      || state_reg.mode == fob_pkg::MODE_STATUS);
  endsequence

  a_prog_duration: assert property (
    otp_busy_o && busy_len < 9'(`FOB_OTP_PROG_CYCLES - 1) && flash_rst_n_i |=> otp_busy_o)
    else $error("OTP write ended early");

  a_busy_bounded: assert property (
    busy_len <= 9'(`FOB_OTP_PROG_CYCLES))
    else $error("OTP write ran too long");

  a_second_starts: assert property (
    s_second_cycle ##0 flash_rst_n_i |=> otp_busy_o && state_reg.mode == fob_pkg::MODE_OTP_BUSY)
    else $error("Second program cycle did not start the write");

  a_locked_flags: assert property (
    s_write_end ##0 state_reg.verdict == fob_pkg::VERDICT_LOCKED && flash_rst_n_i
    |=> state_reg.fail && state_reg.protect)
    else $error("Locked write did not set both flags");

  a_fail_flag: assert property (
    s_write_end ##0 state_reg.verdict == fob_pkg::VERDICT_FAIL && flash_rst_n_i
    |=> state_reg.fail && !otp_busy_o)
    else $error("Failed write did not set program failure");

  a_locked_no_write: assert property (
    mem_bus.we |-> state_reg.verdict == fob_pkg::VERDICT_OK && state_reg.busy_cnt == 8'h00)
    else $error("Rejected write reached the storage");

  a_suspend_ignored: assert property (
    otp_busy_o && capture && cmd == `FOB_CMD_SUSPEND && state_reg.busy_cnt != 8'h00
    |=> otp_busy_o)
    else $error("Suspend interrupted the OTP write");

  a_busy_reads_status: assert property (
    otp_busy_o && flash_rst_n_i |=> dq_o == {8'h00, 3'b000, $past(state_reg.fail), 2'b00,
      $past(state_reg.protect), 1'b0})
    else $error("Read during OTP write did not show status");

  a_reset_pin_array: assert property (
    !flash_rst_n_i |=> state_reg.mode == fob_pkg::MODE_ARRAY && !otp_busy_o)
    else $error("Reset pin did not return to read array");

  a_factory_locked: assert property (
    state_reg.mode == fob_pkg::MODE_IDENT && addr_i == `FOB_LOCK_OFFSET && flash_rst_n_i &&
    !capture ##1 state_reg.mode == fob_pkg::MODE_IDENT |=> !dq_o[`FOB_LOCK_FACTORY_BIT])
    else $error("Factory lock bit read as unlocked");

  a_top_param_block: assert property (
    addr_i[20:12] == 9'h1ff |=> block_num_o == 7'h46 && param_block_o)
    else $error("Topmost parameter block misnumbered");

  a_lockdown_protect: assert property (
    block_lockdown_i && !wp_n_i |=> block_write_protect_o)
    else $error("Locked-down block left writable");

  a_ident_entry: assert property (
    s_idle_command ##0 cmd == `FOB_CMD_READ_ID |=> state_reg.mode == fob_pkg::MODE_IDENT)
    else $error("Identifier command did not select OTP reads");

  a_array_entry: assert property (
    s_idle_command ##0 cmd == `FOB_CMD_READ_ARRAY |=> state_reg.mode == fob_pkg::MODE_ARRAY)
    else $error("Read-array command did not select array reads");

  a_program_entry: assert property (
    s_idle_command ##0 cmd == `FOB_CMD_OTP_PROGRAM
    |=> state_reg.mode == fob_pkg::MODE_OTP_SETUP)
    else $error("Program command did not await its second cycle");

  a_clear_flags: assert property (
    s_idle_command ##0 cmd == `FOB_CMD_CLEAR_STATUS
    |=> !state_reg.fail && !state_reg.protect)
    else $error("Clear status left a flag set");

  a_bad_target: assert property (
    s_second_cycle ##0 id_idx == 4'hf |=> state_reg.verdict == fob_pkg::VERDICT_FAIL)
    else $error("Program outside the OTP region was accepted");

  a_factory_refused: assert property (
    s_second_cycle ##0 id_idx[3:2] == 2'b00 && program_supply_monitor_i
    |=> state_reg.verdict == fob_pkg::VERDICT_LOCKED)
    else $error("Factory word accepted a program");

  a_lock_accepted: assert property (
    s_second_cycle ##0 id_idx == `FOB_LOCK_IDX && program_supply_monitor_i
    |=> state_reg.verdict == fob_pkg::VERDICT_OK)
    else $error("Lock word program was refused");

  a_array_data: assert property (
    state_reg.mode == fob_pkg::MODE_ARRAY |=> dq_o == $past(array_rdata_i))
    else $error("Array mode did not return array data");

  a_main_block: assert property (
    addr_i[20:15] != `FOB_PARAM_REGION
    |=> block_num_o == {1'b0, $past(addr_i[20:15])} && !param_block_o)
    else $error("Main block misnumbered");

  a_supply_protect: assert property (
    !program_supply_monitor_i || !flash_rst_n_i || block_lock_i |=> block_write_protect_o)
    else $error("Block left writable with supply low, pin reset or lock");
endmodule
`default_nettype wire

//--- verif/fob_host.sv
// Purpose: Host memory controller model driving flash command and read cycles.
// Assumes: Signals change 1 ns after the rising clock edge.
// Notes: Released write data shows the inverse of the last value, never a stale copy.
`default_nettype none
module fob_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rdata_oe_i,
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [20:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    oe_n_o = 1'b1;
    addr_o = 21'h000000;
    wdata_o = 16'h0000;
  end
  // Address and data stand through the edge that sees the strobe fall.
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    @(posedge clk_i) #1;
    ce_n_o = 1'b0;
    we_n_o = 1'b0;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i) #1;
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    @(posedge clk_i) #1;
    wdata_o = ~d;
  endtask
  // Ident data trails the address by two clocks, so the address stands two.
  task automatic rd(input logic [20:0] a, output logic [15:0] v, output logic oe);
    @(posedge clk_i) #1;
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    repeat (2) @(posedge clk_i);
    #1;
    v = rdata_i;
    oe = rdata_oe_i;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
  endtask
  // Puts an address on the pins with no cycle, for block decoding checks.
  task automatic hold(input logic [20:0] a);
    addr_o = a;
  endtask
endmodule
`default_nettype wire

//--- verif/fob_ctrl_tb.sv
// Purpose: Self-checking bench for the OTP control block.
// Assumes: One 100 MHz clock; host model drives the flash pins.
// Notes: The OTP program time is the design default of 200 cycles.
`include "fob_regs.svh"
`default_nettype none
module fob_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = `FOB_OTP_PROG_CYCLES;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rst_n = 1'b1, wp_n = 1'b1, sup = 1'b1, lk = 1'b0, lkd = 1'b0;
  logic ce_n, we_n, oe_n, dq_oe, pblk, bwp, busy;
  logic [20:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [15:0] ardata = 16'h5a3c;
  logic [6:0] bnum;
  logic oe;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  fob_ctrl fob_ctrl_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .flash_rst_n_i(rst_n),
    .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .wp_n_i(wp_n),
    .program_supply_monitor_i(sup), .addr_i(addr), .dq_i(wdata), .array_rdata_i(ardata),
    .block_lock_i(lk), .block_lockdown_i(lkd), .dq_o(rdata), .dq_oe_o(dq_oe),
    .block_num_o(bnum), .param_block_o(pblk), .block_write_protect_o(bwp),
    .otp_busy_o(busy));
  fob_host fob_host_i (.clk_i(core_clk_i), .rdata_i(rdata), .rdata_oe_i(dq_oe),
    .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(addr), .wdata_o(wdata));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    fob_host_i.wr(21'h000000, {8'h00, c});
  endtask
  task automatic idr(input logic [20:0] a, input logic [15:0] exp);
    cmd(`FOB_CMD_READ_ID);
    fob_host_i.rd(a, v, oe);
    chk("ident data", exp, v);
    chk("read enable", 16'h0001, {15'h0000, oe});
  endtask
  // Waits out the write under a bound; n holds the busy span seen.
  task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic [15:0] st);
    cmd(`FOB_CMD_OTP_PROGRAM);
    fob_host_i.wr(a, d);
    @(posedge core_clk_i) #1;
    chk("busy start", 16'h0001, {15'h0000, busy});
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge core_clk_i) #1;
      n++;
    end
    fob_host_i.rd(21'h000000, v, oe);
    chk("status", st, v & 16'h0092);
    cmd(`FOB_CMD_CLEAR_STATUS);
  endtask
  task automatic mp(input logic [20:0] a, input logic [3:0] c, input logic [8:0] e);
    fob_host_i.hold(a);
    {lk, lkd, wp_n, sup} = c;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("block", {9'h000, e[8:2]}, {9'h000, bnum});
    chk("param", {15'h0000, e[1]}, {15'h0000, pblk});
    chk("protect", {15'h0000, e[0]}, {15'h0000, bwp});
  endtask
  task automatic t_reset();
    repeat (4) @(posedge core_clk_i);
    chk("reset outs", 16'h0000, {13'h0000, dq_oe, busy, bwp});
    #1 reset_i = 1'b0;
    fob_host_i.rd(21'h001234, v, oe);
    chk("array read", ardata, v);
    cmd(`FOB_CMD_READ_ID);
    cmd(`FOB_CMD_READ_ARRAY);
    fob_host_i.rd(21'h000085, v, oe);
    chk("array again", ardata, v);
    $display("t_reset done");
  endtask
  task automatic t_prog();
    idr(21'h000080, 16'hfffe);
    idr(21'h000085, 16'hffff);
    prog(21'h000085, 16'h1234, 16'h0080);
    chk("busy span", 16'h0001, {15'h0000, n >= P - 2 && n <= P + 1});
    idr(21'h000085, 16'h1234);
    prog(21'h000085, 16'hff0f, 16'h0080);
    idr(21'h000085, 16'h1204);
    cmd(`FOB_CMD_OTP_PROGRAM);
    fob_host_i.wr(21'h000086, 16'habcd);
    cmd(`FOB_CMD_SUSPEND);
    chk("busy on", 16'h0001, {15'h0000, busy});
    fob_host_i.rd(21'h010000, v, oe);
    chk("no array read", 16'h0000, v);
    repeat (P) @(posedge core_clk_i);
    idr(21'h000086, 16'habcd);
    $display("t_prog done");
  endtask
  task automatic t_fail();
    prog(21'h000100, 16'h0000, 16'h0090);
    sup = 1'b0;
    prog(21'h000087, 16'h0000, 16'h0090);
    sup = 1'b1;
    idr(21'h000087, 16'hffff);
    cmd(`FOB_CMD_READ_STATUS);
    fob_host_i.rd(21'h000000, v, oe);
    chk("status command", 16'h0080, v);
    $display("t_fail done");
  endtask
  task automatic t_lock();
    prog(21'h000081, 16'h0000, 16'h0092);
    prog(21'h000080, 16'hfffd, 16'h0080);
    idr(21'h000080, 16'hfffc);
    prog(21'h000086, 16'h0000, 16'h0092);
    idr(21'h000086, 16'habcd);
    prog(21'h000080, 16'hffff, 16'h0080);
    idr(21'h000080, 16'hfffc);
    @(posedge core_clk_i) #1 reset_i = 1'b1;
    @(posedge core_clk_i) #1 reset_i = 1'b0;
    idr(21'h000080, 16'hfffc);
    $display("t_lock done");
  endtask
  task automatic t_map();
    mp(21'h1fffff, 4'b0011, {7'h46, 2'b10});
    mp(21'h1ff000, 4'b0011, {7'h46, 2'b10});
    mp(21'h1f8000, 4'b1011, {7'h3f, 2'b11});
    mp(21'h1f7fff, 4'b0101, {7'h3e, 2'b01});
    mp(21'h1f7fff, 4'b0111, {7'h3e, 2'b00});
    mp(21'h000000, 4'b0010, {7'h00, 2'b01});
    mp(21'h008000, 4'b0011, {7'h01, 2'b00});
    rst_n = 1'b0;
    cmd(`FOB_CMD_READ_ID);
    chk("pin protect", 16'h0001, {15'h0000, bwp});
    rst_n = 1'b1;
    fob_host_i.rd(21'h000080, v, oe);
    chk("pin array", ardata, v);
    $display("t_map done");
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    test_done();
  end
  initial begin
    t_reset();
    t_prog();
    t_fail();
    t_lock();
    t_map();
    test_done();
  end
endmodule
`default_nettype wire
